// *** dv/tb.sv ***
// Purpose: Self-checking bench for the timer modulo and channel block
// Assumes: Counter runs every clk; waits are sized from that
// Notes:   Flags are seen through register reads and the two interrupt request outputs
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic                   clk;
   logic                   reset_n;
   tmcm_pkg::tmcm_busreq_t busReq;
   logic [7:0]             rdata;
   logic                   debugMode;
   logic                   pinDrive;
   logic                   chanPinIn;
   logic                   chanPinOut;
   logic                   chanPinOutEn;
   logic                   ovfIrq;
   logic                   chanIrq;
   int                     num_errors;
   int                     compares;
   int                     cycles;
   // Module SC, channel SC, expected pin enable
   localparam logic [16:0] ROWS [8] = '{{8'h00, 8'h00, 1'b0}, {8'h00, 8'h30, 1'b0},
      {8'h20, 8'h30, 1'b0}, {8'h00, 8'h04, 1'b0}, {8'h00, 8'h14, 1'b1},
      {8'h00, 8'h34, 1'b1}, {8'h20, 8'h08, 1'b1}, {8'h00, 8'h00, 1'b0}};

   tmcm_channel_timer uut (.clk(clk), .reset_n(reset_n), .busReq(busReq), .rdata(rdata),
      .backgroundDebugMode(debugMode), .chanPinIn(chanPinIn), .chanPinOut(chanPinOut),
      .chanPinOutEn(chanPinOutEn), .overflowIrqReq(ovfIrq), .channelIrqReq(chanIrq));
   tmcm_pin_model pin (.drive(pinDrive), .chanPinOut(chanPinOut),
      .chanPinOutEn(chanPinOutEn), .chanPinIn(chanPinIn));

   task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic chk1(input string name, input logic exp, input logic got);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %b seen %b", name, exp, got);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      busReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      busReq <= '0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic bus_rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      busReq <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      busReq <= '0;
      #1 chk8("rdata", exp, rdata);
   endtask
   // Counter restart first, so the overflow moment is known
   task automatic restart_read(input logic [7:0] exp);
      bus_wr(tmcm_pkg::ADDR_CNT_LOW, 8'h00);
      tick(12);
      bus_rd(tmcm_pkg::ADDR_MODULE_SC, exp);
   endtask
   task automatic give_verdict();
      if (num_errors == 0 && compares > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   // Whole run is about 1100 cycles
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         give_verdict();
      end
   end

   initial begin
      reset_n = 1'b0;
      busReq = '0;
      debugMode = 1'b0;
      pinDrive = 1'b0;
      num_errors = 0;
      compares = 0;
      cycles = 0;
      tick(6);
      reset_n <= 1'b1;
      bus_rd(tmcm_pkg::ADDR_MOD_HIGH, 8'h00);
      bus_rd(tmcm_pkg::ADDR_MOD_LOW, 8'h00);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h00);
      foreach (ROWS[i]) begin
         bus_wr(tmcm_pkg::ADDR_MODULE_SC, ROWS[i][16:9]);
         bus_wr(tmcm_pkg::ADDR_CHAN_SC, ROWS[i][8:1]);
         bus_rd(tmcm_pkg::ADDR_MODULE_SC, ROWS[i][16:9]);
         bus_rd(tmcm_pkg::ADDR_CHAN_SC, ROWS[i][8:1]);
         chk1("chanPinOutEn", ROWS[i][0], chanPinOutEn);
      end
      // Half pair must not reach the active modulo
      bus_wr(tmcm_pkg::ADDR_MOD_LOW, 8'h04);
      restart_read(8'h00);
      bus_wr(tmcm_pkg::ADDR_MODULE_SC, 8'h00);
      bus_wr(tmcm_pkg::ADDR_MOD_HIGH, 8'h00);
      restart_read(8'h00);
      bus_wr(tmcm_pkg::ADDR_MOD_LOW, 8'h04);
      restart_read(8'h80);
      bus_wr(tmcm_pkg::ADDR_MODULE_SC, 8'hc0);
      #1 chk1("overflowIrqReq", 1'b1, ovfIrq);
      debugMode <= 1'b1;
      bus_wr(tmcm_pkg::ADDR_MOD_HIGH, 8'h01);
      debugMode <= 1'b0;
      bus_rd(tmcm_pkg::ADDR_MODULE_SC, 8'hc0);
      bus_wr(tmcm_pkg::ADDR_MODULE_SC, 8'h00);
      restart_read(8'h00);
      // Capture on rising edge only, then the clearing sequence
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h04);
      pinDrive <= 1'b1;
      tick(8);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h84);
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h84);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h84);
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h04);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h04);
      pinDrive <= 1'b0;
      tick(8);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h04);
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h4c);
      pinDrive <= 1'b1;
      tick(8);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'hcc);
      chk1("channelIrqReq", 1'b1, chanIrq);
      // Event between the read and the clearing write
      pinDrive <= 1'b0;
      tick(8);
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h4c);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'hcc);
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h4c);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h4c);
      chk1("channelIrqReq", 1'b0, chanIrq);
      // Output compare: set, then clear on match
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h1c);
      bus_wr(tmcm_pkg::ADDR_CHAN_VAL_LOW, 8'h10);
      tick(300);
      #1 chk1("chanPinOut", 1'b1, chanPinOut);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h9c);
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h18);
      tick(300);
      #1 chk1("chanPinOut", 1'b0, chanPinOut);
      // Edge-aligned high-true with modulo 0x0104: low after the match, high after the wrap
      bus_wr(tmcm_pkg::ADDR_CHAN_SC, 8'h28);
      bus_wr(tmcm_pkg::ADDR_CNT_LOW, 8'h00);
      tick(100);
      #1 chk1("chanPinOut", 1'b0, chanPinOut);
      tick(165);
      #1 chk1("chanPinOut", 1'b1, chanPinOut);
      // Mid-run reset must bring modulo and channel control back to zero
      reset_n <= 1'b0;
      tick(2);
      reset_n <= 1'b1;
      bus_rd(tmcm_pkg::ADDR_MOD_HIGH, 8'h00);
      bus_rd(tmcm_pkg::ADDR_CHAN_SC, 8'h00);
      give_verdict();
   end
endmodule // tb
`default_nettype wire

// *** dv/tmcm_pin_model.sv ***
// Purpose: Far-side model of the channel pin
// Assumes: No pull on the pin; the outside drives it whenever the block lets go
// Notes:   Register side is driven by the bench tasks
`default_nettype none
module tmcm_pin_model (
   input  wire logic drive,
   input  wire logic chanPinOut,
   input  wire logic chanPinOutEn,
   output logic      chanPinIn
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released pin follows the outside level
   assign chanPinIn = chanPinOutEn ? chanPinOut : drive;
endmodule // tmcm_pin_model
`default_nettype wire

// *** hdl/tmcm_channel_timer.sv ***
// Purpose: 16-bit timer with buffered modulo and one capture/compare/PWM channel
// Assumes: Counter advances every clk outside debug; prescaler and clock select absent
// Notes:   Channel value writes land directly outside capture mode; only the modulo value is buffered
// Operation
// - Overflow flag sets on the counter clock after reaching the modulo value.
// - Reset clears the 16-bit modulo value to zero.
// - Modulo byte writes go to a buffer, loaded once both bytes arrive.
// - Any module status/control write restarts the modulo write sequence.
// - During debug mode the modulo buffer latch state stays frozen, except that a module status/control write clears it.
// - During debug mode modulo byte writes update the active register directly.
// - Channel event flag in bit 7 sets on each channel event.
// - Flag clears by read-while-set then writing zero; writing one does nothing.
// - An event between the read and clearing write keeps the flag set.
// - Bit 6 enables channel interrupts; reset clears enable and flag.
// - Mode select B, A and edge/level bits sit in bits 5..2.
// - Edge/level 00 releases the pin whatever the other mode bits say.
// - Mode 00 captures rising, falling or both edges per edge/level.
// - Mode 01 toggles, clears or sets the output on a match.
// - Mode select B gives edge-aligned PWM, high-true or low-true.
// - Up-down select gives center-aligned PWM acting on both up-count and down-count matches.
// - Up-down select makes the counter count up then down.
// - Up mode counts zero to modulo then reloads zero, setting overflow.
// - Capture edge copies counter to channel value and sets the flag.
//
// Decided for this implementation: the register addresses and the address-and-strobe port.
`default_nettype none
module tmcm_channel_timer (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire tmcm_pkg::tmcm_busreq_t busReq,
   output logic [7:0]                  rdata,
   input  wire logic                   backgroundDebugMode,
   input  wire logic                   chanPinIn,
   output logic                        chanPinOut,
   output logic                        chanPinOutEn,
   output logic                        overflowIrqReq,
   output logic                        channelIrqReq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   logic [15:0]            count;
   logic                   countDown;
   logic                   ovfFlag;
   logic                   ovfArmed;
   logic                   ovfIrqEnable;
   logic                   upDown;
   logic [15:0]            modulo;
   logic [7:0]             bufHigh;
   logic [7:0]             bufLow;
   logic                   hiLatched;
   logic                   loLatched;
   tmcm_pkg::tmcm_chanctl_t chanCtl;
   logic                   chanArmed;
   logic [15:0]            chanValue;
   logic                   pinLevel;

   logic [15:0]            next_count;
   logic                   next_countDown;
   logic                   next_ovfFlag;
   logic                   next_ovfArmed;
   logic                   next_ovfIrqEnable;
   logic                   next_upDown;
   logic [15:0]            next_modulo;
   logic [7:0]             next_bufHigh;
   logic [7:0]             next_bufLow;
   logic                   next_hiLatched;
   logic                   next_loLatched;
   tmcm_pkg::tmcm_chanctl_t next_chanCtl;
   logic                   next_chanArmed;
   logic [15:0]            next_chanValue;
   logic                   next_pinLevel;
   logic [7:0]             next_rdata;

   logic                   tick;
   logic [15:0]            topValue;
   logic                   ovfEvent;
   logic                   wrapToZero;
   logic                   match;
   logic                   captureEdge;
   logic                   chanEvent;
   logic                   pinRise;
   logic                   pinFall;
   logic                   wrMsc;
   logic                   wrCsc;
   tmcm_pkg::tmcm_mode_t   mode;

   function automatic logic isWrite(input tmcm_pkg::tmcm_busreq_t req, input logic [3:0] a);
      return req.wr && (req.addr == a);
   endfunction

   function automatic tmcm_pkg::tmcm_mode_t decodeMode(input logic ud,
                                                       input tmcm_pkg::tmcm_chanctl_t c);
      if ({c.edgeLevelB, c.edgeLevelA} == 2'h0) begin
         return tmcm_pkg::MODE_RELEASE;
      end else if (ud) begin
         return tmcm_pkg::MODE_CENTER_PWM;
      end else if (c.modeSelectB) begin
         return tmcm_pkg::MODE_EDGE_PWM;
      end else if (c.modeSelectA) begin
         return tmcm_pkg::MODE_COMPARE;
      end else begin
         return tmcm_pkg::MODE_CAPTURE;
      end
   endfunction

   tmcm_pin_sync u_pin_sync (
      .clk     (clk),
      .reset_n (reset_n),
      .pinIn   (chanPinIn),
      .rise    (pinRise),
      .fall    (pinFall)
   );

   // Debug mode freezes the counter, so no counter clock runs then
   assign tick     = !backgroundDebugMode;
   assign topValue = (modulo == tmcm_pkg::MODULO_RESET) ? tmcm_pkg::FREE_RUN_TOP : modulo;
   assign wrMsc    = isWrite(busReq, tmcm_pkg::ADDR_MODULE_SC);
   assign wrCsc    = isWrite(busReq, tmcm_pkg::ADDR_CHAN_SC);
   assign mode     = decodeMode(upDown, chanCtl);

   // Counter, overflow flag and module status/control
   always_comb begin
      next_count        = count;
      next_countDown    = countDown;
      next_ovfIrqEnable = ovfIrqEnable;
      next_upDown       = upDown;
      ovfEvent          = 1'b0;
      wrapToZero        = 1'b0;
      if (tick) begin
         if (upDown && !countDown) begin
            if (count == topValue) begin
               next_count     = count - 16'h0001;
               next_countDown = 1'b1;
               ovfEvent       = 1'b1;
            end else begin
               next_count = count + 16'h0001;
            end
         end else if (upDown) begin
            if (count == tmcm_pkg::COUNT_RESET) begin
               next_count     = count + 16'h0001;
               next_countDown = 1'b0;
            end else begin
               next_count = count - 16'h0001;
            end
         end else if (count == topValue) begin
            next_count     = tmcm_pkg::COUNT_RESET;
            next_countDown = 1'b0;
            ovfEvent       = 1'b1;
            wrapToZero     = 1'b1;
         end else begin
            next_count     = count + 16'h0001;
            next_countDown = 1'b0;
         end
      end
      if (isWrite(busReq, tmcm_pkg::ADDR_CNT_HIGH)
          || isWrite(busReq, tmcm_pkg::ADDR_CNT_LOW)) begin
         next_count     = tmcm_pkg::COUNT_RESET;
         next_countDown = 1'b0;
      end
      next_ovfArmed = ovfArmed;
      next_ovfFlag  = ovfFlag;
      if (busReq.rd && busReq.addr == tmcm_pkg::ADDR_MODULE_SC && ovfFlag) begin
         next_ovfArmed = 1'b1;
      end
      if (wrMsc) begin
         next_ovfIrqEnable = busReq.wdata[tmcm_pkg::MSC_OVF_IE_BIT];
         next_upDown       = busReq.wdata[tmcm_pkg::MSC_UPDOWN_BIT];
         if (ovfArmed && !busReq.wdata[tmcm_pkg::MSC_OVF_BIT]) begin
            next_ovfFlag = 1'b0;
         end
         next_ovfArmed = 1'b0;
      end
      // A fresh overflow always wins over a clear in flight
      if (ovfEvent) begin
         next_ovfFlag  = 1'b1;
         next_ovfArmed = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         count        <= tmcm_pkg::COUNT_RESET;
         countDown    <= 1'b0;
         ovfFlag      <= 1'b0;
         ovfArmed     <= 1'b0;
         ovfIrqEnable <= 1'b0;
         upDown       <= 1'b0;
      end else begin
         count        <= next_count;
         countDown    <= next_countDown;
         ovfFlag      <= next_ovfFlag;
         ovfArmed     <= next_ovfArmed;
         ovfIrqEnable <= next_ovfIrqEnable;
         upDown       <= next_upDown;
      end
   end

   // Modulo write buffer; loads once both halves have arrived, in either order
   always_comb begin
      next_modulo    = modulo;
      next_bufHigh   = bufHigh;
      next_bufLow    = bufLow;
      next_hiLatched = hiLatched;
      next_loLatched = loLatched;
      if (backgroundDebugMode) begin
         if (isWrite(busReq, tmcm_pkg::ADDR_MOD_HIGH)) begin
            next_modulo[15:8] = busReq.wdata;
         end
         if (isWrite(busReq, tmcm_pkg::ADDR_MOD_LOW)) begin
            next_modulo[7:0] = busReq.wdata;
         end
      end else if (isWrite(busReq, tmcm_pkg::ADDR_MOD_HIGH)) begin
         next_bufHigh = busReq.wdata;
         if (loLatched) begin
            next_modulo    = {busReq.wdata, bufLow};
            next_loLatched = 1'b0;
         end else begin
            next_hiLatched = 1'b1;
         end
      end else if (isWrite(busReq, tmcm_pkg::ADDR_MOD_LOW)) begin
         next_bufLow = busReq.wdata;
         if (hiLatched) begin
            next_modulo    = {bufHigh, busReq.wdata};
            next_hiLatched = 1'b0;
         end else begin
            next_loLatched = 1'b1;
         end
      end
      if (wrMsc) begin
         next_hiLatched = 1'b0;
         next_loLatched = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         modulo    <= tmcm_pkg::MODULO_RESET;
         bufHigh   <= 8'h00;
         bufLow    <= 8'h00;
         hiLatched <= 1'b0;
         loLatched <= 1'b0;
      end else begin
         modulo    <= next_modulo;
         bufHigh   <= next_bufHigh;
         bufLow    <= next_bufLow;
         hiLatched <= next_hiLatched;
         loLatched <= next_loLatched;
      end
   end

   // Channel: capture, compare and PWM output
   assign match = tick && (count == chanValue) && (mode != tmcm_pkg::MODE_RELEASE)
                  && (mode != tmcm_pkg::MODE_CAPTURE);
   assign captureEdge = (mode == tmcm_pkg::MODE_CAPTURE)
                        && ((pinRise && chanCtl.edgeLevelA)
                        || (pinFall && chanCtl.edgeLevelB));
   assign chanEvent = match || captureEdge;

   always_comb begin
      next_chanCtl   = chanCtl;
      next_chanArmed = chanArmed;
      next_chanValue = chanValue;
      next_pinLevel  = pinLevel;
      if (busReq.rd && busReq.addr == tmcm_pkg::ADDR_CHAN_SC && chanCtl.flag) begin
         next_chanArmed = 1'b1;
      end
      if (wrCsc) begin
         next_chanCtl           = busReq.wdata;
         next_chanCtl.unused    = 2'h0;
         next_chanCtl.flag      = chanCtl.flag;
         if (chanArmed && !busReq.wdata[tmcm_pkg::CSC_FLAG_BIT]) begin
            next_chanCtl.flag = 1'b0;
         end
         next_chanArmed = 1'b0;
      end
      if (mode != tmcm_pkg::MODE_CAPTURE) begin
         if (isWrite(busReq, tmcm_pkg::ADDR_CHAN_VAL_HIGH)) begin
            next_chanValue[15:8] = busReq.wdata;
         end
         if (isWrite(busReq, tmcm_pkg::ADDR_CHAN_VAL_LOW)) begin
            next_chanValue[7:0] = busReq.wdata;
         end
      end
      if (captureEdge) begin
         next_chanValue = count;
      end
      unique case (mode)
         tmcm_pkg::MODE_COMPARE: begin
            if (match) begin
               unique case ({chanCtl.edgeLevelB, chanCtl.edgeLevelA})
                  2'h1: next_pinLevel = !pinLevel;
                  2'h2: next_pinLevel = 1'b0;
                  2'h3: next_pinLevel = 1'b1;
                  default: next_pinLevel = pinLevel;
               endcase
            end
         end
         tmcm_pkg::MODE_EDGE_PWM: begin
            // Period start drives the active level; a match ends the pulse
            if (wrapToZero) begin
               next_pinLevel = !chanCtl.edgeLevelA;
            end
            if (match) begin
               next_pinLevel = chanCtl.edgeLevelA;
            end
         end
         tmcm_pkg::MODE_CENTER_PWM: begin
            if (match) begin
               next_pinLevel = countDown ? !chanCtl.edgeLevelA : chanCtl.edgeLevelA;
            end
         end
         tmcm_pkg::MODE_RELEASE,
         tmcm_pkg::MODE_CAPTURE: begin
            next_pinLevel = pinLevel;
         end
      endcase
      // Set wins over a clear in the same cycle
      if (chanEvent) begin
         next_chanCtl.flag = 1'b1;
         next_chanArmed    = 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         chanCtl   <= tmcm_pkg::CHAN_SC_RESET;
         chanArmed <= 1'b0;
         chanValue <= tmcm_pkg::CHAN_VALUE_RESET;
         pinLevel  <= 1'b0;
      end else begin
         chanCtl   <= next_chanCtl;
         chanArmed <= next_chanArmed;
         chanValue <= next_chanValue;
         pinLevel  <= next_pinLevel;
      end
   end

   // Register read port, data valid only in the cycle after the strobe
   always_comb begin
      next_rdata = tmcm_pkg::READ_IDLE;
      if (busReq.rd) begin
         unique case (busReq.addr)
            tmcm_pkg::ADDR_MODULE_SC:     next_rdata = {ovfFlag, ovfIrqEnable, upDown, 5'h00};
            tmcm_pkg::ADDR_CNT_HIGH:      next_rdata = count[15:8];
            tmcm_pkg::ADDR_CNT_LOW:       next_rdata = count[7:0];
            tmcm_pkg::ADDR_MOD_HIGH:      next_rdata = modulo[15:8];
            tmcm_pkg::ADDR_MOD_LOW:       next_rdata = modulo[7:0];
            tmcm_pkg::ADDR_CHAN_SC:       next_rdata = chanCtl;
            tmcm_pkg::ADDR_CHAN_VAL_HIGH: next_rdata = chanValue[15:8];
            tmcm_pkg::ADDR_CHAN_VAL_LOW:  next_rdata = chanValue[7:0];
            default:                      next_rdata = tmcm_pkg::READ_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata <= tmcm_pkg::READ_IDLE;
      end else begin
         rdata <= next_rdata;
      end
   end

   assign chanPinOut     = pinLevel;
   assign chanPinOutEn   = (mode != tmcm_pkg::MODE_RELEASE) && (mode != tmcm_pkg::MODE_CAPTURE);
   assign overflowIrqReq = ovfFlag && ovfIrqEnable;
   assign channelIrqReq  = chanCtl.flag && chanCtl.irqEnable;

   property p_ovf_set;
      tick && !upDown && count == topValue |=> ovfFlag && count == 16'h0000;
   endproperty
   a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set on wrap");

   property p_mod_reset;
      reset_n && !$past(reset_n) |-> modulo == 16'h0000 && !hiLatched && !loLatched;
   endproperty
   a_mod_reset: assert property (p_mod_reset) else $error("modulo not zero after reset");

   property p_mod_buffered;
      isWrite(busReq, tmcm_pkg::ADDR_MOD_HIGH) && !backgroundDebugMode && !loLatched
         |=> modulo == $past(modulo) && hiLatched;
   endproperty
   a_mod_buffered: assert property (p_mod_buffered) else $error("modulo not buffered");

   property p_msc_restart;
      wrMsc |=> !hiLatched && !loLatched;
   endproperty
   a_msc_restart: assert property (p_msc_restart) else $error("coherency not restarted");

   property p_bdm_freeze;
      backgroundDebugMode && !wrMsc |=> $stable(hiLatched) && $stable(loLatched);
   endproperty
   a_bdm_freeze: assert property (p_bdm_freeze) else $error("latches moved in debug");

   property p_bdm_direct;
      backgroundDebugMode && isWrite(busReq, tmcm_pkg::ADDR_MOD_LOW)
         |=> modulo[7:0] == $past(busReq.wdata);
   endproperty
   a_bdm_direct: assert property (p_bdm_direct) else $error("debug write not direct");

   property p_flag_set;
      chanEvent |=> chanCtl.flag ##1 1'b1;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("channel flag not set");

   property p_write_one;
      wrCsc && busReq.wdata[tmcm_pkg::CSC_FLAG_BIT] |=> !$fell(chanCtl.flag);
   endproperty
   a_write_one: assert property (p_write_one) else $error("writing one cleared flag");

   sequence s_qual_read;
      busReq.rd && busReq.addr == tmcm_pkg::ADDR_CHAN_SC && chanCtl.flag && !chanEvent;
   endsequence
   sequence s_late_event;
      chanEvent && !wrCsc;
   endsequence
   property p_arm;
      s_qual_read |=> chanArmed;
   endproperty
   a_arm: assert property (p_arm) else $error("qualifying read not armed");
   property p_flag_keep;
      s_late_event |=> chanCtl.flag && !chanArmed;
   endproperty
   a_flag_keep: assert property (p_flag_keep) else $error("pending event lost");

   property p_release;
      {chanCtl.edgeLevelB, chanCtl.edgeLevelA} == 2'h0 |-> !chanPinOutEn;
   endproperty
   a_release: assert property (p_release) else $error("pin not released");

   property p_capture;
      captureEdge |=> chanValue == $past(count) && chanCtl.flag;
   endproperty
   a_capture: assert property (p_capture) else $error("capture value wrong");

   property p_count_down;
      tick && upDown && countDown && count != 16'h0000 && !wrMsc
         && !isWrite(busReq, tmcm_pkg::ADDR_CNT_HIGH) && !isWrite(busReq, tmcm_pkg::ADDR_CNT_LOW)
         |=> count == $past(count) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("down count wrong");
endmodule // tmcm_channel_timer
`default_nettype wire

// *** hdl/tmcm_pin_sync.sv ***
// Purpose: Three-stage synchroniser with edge pulses for the channel pin
// Assumes: Pin is asynchronous to clk
// Notes:   A change counts only once stages two and three agree
`default_nettype none
module tmcm_pin_sync (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic pinIn,
   output logic      rise,
   output logic      fall
);
   logic stage1;
   logic stage2;
   logic stage3;
   logic level;
   logic next_level;

   always_comb begin
      next_level = (stage2 == stage3) ? stage3 : level;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
         stage3 <= 1'b0;
         level  <= 1'b0;
      end else begin
         stage1 <= pinIn;
         stage2 <= stage1;
         stage3 <= stage2;
         level  <= next_level;
      end
   end

   assign rise = next_level && !level;
   assign fall = !next_level && level;
endmodule // tmcm_pin_sync
`default_nettype wire

// *** hdl/tmcm_pkg.sv ***
// Purpose: Shared constants and types for the timer modulo and channel block
// Assumes: 8-bit register port, one channel, counter clock equal to clk
// Notes:   Byte addresses below are the register port indices
`default_nettype none
package tmcm_pkg;
   localparam logic [3:0]  ADDR_MODULE_SC     = 4'h0;
   localparam logic [3:0]  ADDR_CNT_HIGH      = 4'h1;
   localparam logic [3:0]  ADDR_CNT_LOW       = 4'h2;
   localparam logic [3:0]  ADDR_MOD_HIGH      = 4'h3;
   localparam logic [3:0]  ADDR_MOD_LOW       = 4'h4;
   localparam logic [3:0]  ADDR_CHAN_SC       = 4'h5;
   localparam logic [3:0]  ADDR_CHAN_VAL_HIGH = 4'h6;
   localparam logic [3:0]  ADDR_CHAN_VAL_LOW  = 4'h7;

   localparam int          MSC_OVF_BIT        = 7;
   localparam int          MSC_OVF_IE_BIT     = 6;
   localparam int          MSC_UPDOWN_BIT     = 5;
   localparam int          CSC_FLAG_BIT       = 7;

   localparam logic [15:0] MODULO_RESET       = 16'h0000;
   localparam logic [15:0] COUNT_RESET        = 16'h0000;
   localparam logic [15:0] CHAN_VALUE_RESET   = 16'h0000;
   localparam logic [7:0]  CHAN_SC_RESET      = 8'h00;
   localparam logic [15:0] FREE_RUN_TOP       = 16'hffff;
   localparam logic [7:0]  READ_IDLE          = 8'h00;

   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tmcm_busreq_t;

   typedef struct packed {
      logic       flag;
      logic       irqEnable;
      logic       modeSelectB;
      logic       modeSelectA;
      logic       edgeLevelB;
      logic       edgeLevelA;
      logic [1:0] unused;
   } tmcm_chanctl_t;

   typedef enum logic [2:0] {
      MODE_RELEASE,
      MODE_CAPTURE,
      MODE_COMPARE,
      MODE_EDGE_PWM,
      MODE_CENTER_PWM
   } tmcm_mode_t;
endpackage
`default_nettype wire
